// ==== hdl/tcs_pkg.sv ====
// Purpose: shared constants for the timer clock select and gating block
// Assumes: 8-bit special function register port, single system clock
// Notes: counts are in system clock cycles
package tcs_pkg;
  // ************************************
  // register map
  // ************************************
  localparam logic [7:0] TCS_TIMER_CLOCK_CONTROL_ADDR = 8'h8E;
  localparam logic [7:0] TCS_TIMER_CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TCS_TIMER_CLOCK_CONTROL_WMASK = 8'h3F;
  localparam int TCS_SCALE_LSB = 0;
  localparam int TCS_T0_SYS_BIT = 2;
  localparam int TCS_T1_SYS_BIT = 3;
  localparam int TCS_T2L_SYS_BIT = 4;
  localparam int TCS_T2H_SYS_BIT = 5;
  // ************************************
  // prescale encodings and divisors
  // ************************************
  localparam logic [1:0] TCS_SCALE_DIV12 = 2'h0;
  localparam logic [1:0] TCS_SCALE_DIV4 = 2'h1;
  localparam logic [1:0] TCS_SCALE_DIV48 = 2'h2;
  localparam logic [1:0] TCS_SCALE_EXT8 = 2'h3;
  localparam logic [5:0] TCS_DIV12_CYC = 6'hC;
  localparam logic [5:0] TCS_DIV4_CYC = 6'h4;
  localparam logic [5:0] TCS_DIV48_CYC = 6'h30;
  localparam logic [2:0] TCS_EXT_DIV_LAST = 3'h7;
  localparam int TCS_CNT_W = 13;
  localparam int TCS_LOW_W = 5;
  localparam logic [5:0] TCS_PRESC_RESET = 6'h00;
endpackage

// ==== hdl/tcs_presc_if.sv ====
// Purpose: carrier between the gating top and the shared prescaler
// Assumes: all signals on the system clock
// Notes: ticks are one-cycle enables
`timescale 1ns/1ps
`default_nettype none
interface tcs_presc_if;
  logic ce;
  logic [1:0] scale_sel;
  logic tick_scaled;
  logic tick_div12;
  logic tick_ext8;
  modport ctrl (output ce, output scale_sel, input tick_scaled, input tick_div12, input tick_ext8);
  modport presc (input ce, input scale_sel, output tick_scaled, output tick_div12, output tick_ext8);
endinterface
`default_nettype wire

// ==== hdl/tcs_prescaler.sv ====
// Purpose: shared prescaler: system clock /12, /4, /48 and external clock /8
// Assumes: external clock slower than half the system clock
// Notes: one free-running modulo-48 counter serves all three divisors
`timescale 1ns/1ps
`default_nettype none
module tcs_prescaler
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // external clock pin
  input wire logic ext_clk_i,
  // prescaler carrier
  tcs_presc_if.presc bus
);
  import tcs_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [2:0] ext_cnt;
    logic tick_scaled;
    logic tick_div12;
    logic tick_ext8;
  } tcs_presc_s;

  tcs_presc_s st_q, st_d;

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic t12;
    logic t4;
    logic t48;
    logic t8;
    t12 = 1'b0;
    t4 = 1'b0;
    t48 = 1'b0;
    t8 = 1'b0;
    st_d = st_q;
    st_d.cnt = (st_q.cnt == TCS_DIV48_CYC - 6'h1) ? TCS_PRESC_RESET : st_q.cnt + 6'h1;
    // /48 period is a multiple of 12 and 4, so all ticks stay evenly spaced
    t12 = (st_q.cnt % TCS_DIV12_CYC) == (TCS_DIV12_CYC - 6'h1);
    t4 = (st_q.cnt % TCS_DIV4_CYC) == (TCS_DIV4_CYC - 6'h1);
    t48 = st_q.cnt == (TCS_DIV48_CYC - 6'h1);
    // external clock: two-stage sync, then rising edges counted by 8
    st_d.ext_s1 = ext_clk_i;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.ext_s3 = st_q.ext_s2;
    t8 = 1'b0;
    if (st_q.ext_s2 && !st_q.ext_s3) begin
      st_d.ext_cnt = st_q.ext_cnt + 3'h1;
      t8 = st_q.ext_cnt == TCS_EXT_DIV_LAST;
    end
    unique case (bus.scale_sel)
      TCS_SCALE_DIV12: st_d.tick_scaled = t12;
      TCS_SCALE_DIV4: st_d.tick_scaled = t4;
      TCS_SCALE_DIV48: st_d.tick_scaled = t48;
      TCS_SCALE_EXT8: st_d.tick_scaled = t8;
    endcase
    st_d.tick_div12 = t12;
    st_d.tick_ext8 = t8;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else if (bus.ce) begin
      st_q <= st_d;
    end
  end

  assign bus.tick_scaled = st_q.tick_scaled;
  assign bus.tick_div12 = st_q.tick_div12;
  assign bus.tick_ext8 = st_q.tick_ext8;
endmodule
`default_nettype wire

// ==== hdl/tcs_timer_clk_gate.sv ====
// Purpose: clock select and run gating for timers 0 and 1, clock select for timer 2
// Assumes: control bits of other registers arrive as plain same-clock inputs
// Notes: timers 0 and 1 are shown in their 13-bit mode
// Summary of operation
// - timer 0 counts only if run set and gate off or gate input active
// - timer 0 gate input active level set by gate_a_polarity
// - setting run never clears or reloads the count
// - timer 1 is 13-bit, gated like timer 0 through its own bits
// - timer 1 uses gate input a with active level from gate_b_polarity
// - timer 0 select 1 uses system clock, 0 uses selected prescaler output
// - timer 1 select 1 uses system clock, 0 uses shared prescaler output
// - prescale 00 /12, 01 /4, 10 /48, 11 synchronised external /8
// - timer 2 byte select 1 system clock, 0 source from ext-clock bit
// - timer 2 high-byte select matters only in split 8-bit mode
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_clk_gate
  import tcs_pkg::*;
#(
  parameter int CNT_W = TCS_CNT_W
)
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // special function register port
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WE_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // timer control and mode bits
  input wire logic TIMER0_RUN_I,
  input wire logic TIMER0_GATE_ENABLE_I,
  input wire logic TIMER0_COUNTER_MODE_I,
  input wire logic TIMER1_RUN_I,
  input wire logic TIMER1_GATE_ENABLE_I,
  input wire logic TIMER1_COUNTER_MODE_I,
  input wire logic GATE_A_POLARITY_I,
  input wire logic GATE_B_POLARITY_I,
  input wire logic TIMER2_EXT_CLOCK_SELECT_I,
  input wire logic TIMER2_SPLIT_MODE_I,
  // pins
  input wire logic EXTERNAL_GATE_INPUT_A_I,
  input wire logic EXT_CLK_I,
  input wire logic TIMER0_EVENT_I,
  input wire logic TIMER1_EVENT_I,
  // count loads
  input wire logic TIMER0_LOAD_LOW_I,
  input wire logic TIMER0_LOAD_HIGH_I,
  input wire logic TIMER1_LOAD_LOW_I,
  input wire logic TIMER1_LOAD_HIGH_I,
  input wire logic [7:0] LOAD_DATA_I,
  // timer state
  output logic [CNT_W-1:0] TIMER0_COUNT_O,
  output logic [CNT_W-1:0] TIMER1_COUNT_O,
  output logic TIMER0_OVERFLOW_O,
  output logic TIMER1_OVERFLOW_O,
  output logic TIMER0_ENABLED_O,
  output logic TIMER1_ENABLED_O,
  output logic TIMER2_LOW_TICK_O,
  output logic TIMER2_HIGH_TICK_O,
  output logic [7:0] TIMER_CLOCK_CONTROL_O
);
  import tcs_pkg::*;

  // ************************************
  // helpers
  // ************************************
  function automatic logic gate_open(input logic run, input logic gate_en, input logic gate_in,
                                     input logic pol);
    gate_open = run && (!gate_en || (gate_in == pol));
  endfunction

  // one decode shared by write and read paths
  function automatic logic is_timer_clock_control(input logic [7:0] addr);
    is_timer_clock_control = addr == TCS_TIMER_CLOCK_CONTROL_ADDR;
  endfunction

  typedef struct packed {
    logic [7:0] timer_clock_control;
    logic [7:0] rdata;
    logic gate_s1;
    logic gate_s2;
    logic [1:0] ev_s1;
    logic [1:0] ev_s2;
    logic [1:0] ev_s3;
    logic [1:0][CNT_W-1:0] cnt;
    logic [1:0] ovf;
    logic [1:0] en;
    logic t2_low;
    logic t2_high;
  } tcs_state_s;

  tcs_state_s st_q, st_d;
  tcs_presc_if presc_bus ();

  assign presc_bus.ce = CE_I;
  assign presc_bus.scale_sel = st_q.timer_clock_control[TCS_SCALE_LSB +: 2];

  tcs_prescaler u_presc (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .ext_clk_i(EXT_CLK_I),
    .bus(presc_bus)
  );

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic [1:0] run;
    logic [1:0] gen;
    logic [1:0] cmode;
    logic [1:0] pol;
    logic [1:0] sys;
    logic [1:0] ld_lo;
    logic [1:0] ld_hi;
    logic [1:0] ev_fall;
    logic tick;
    logic t2_src;
    ev_fall = 2'b00;
    tick = 1'b0;
    t2_src = 1'b0;
    run = {TIMER1_RUN_I, TIMER0_RUN_I};
    gen = {TIMER1_GATE_ENABLE_I, TIMER0_GATE_ENABLE_I};
    cmode = {TIMER1_COUNTER_MODE_I, TIMER0_COUNTER_MODE_I};
    pol = {GATE_B_POLARITY_I, GATE_A_POLARITY_I};
    sys = {st_q.timer_clock_control[TCS_T1_SYS_BIT], st_q.timer_clock_control[TCS_T0_SYS_BIT]};
    ld_lo = {TIMER1_LOAD_LOW_I, TIMER0_LOAD_LOW_I};
    ld_hi = {TIMER1_LOAD_HIGH_I, TIMER0_LOAD_HIGH_I};
    st_d = st_q;
    // register port; reserved bits never stored so they read 0
    if (SFR_WE_I && is_timer_clock_control(SFR_ADDR_I)) begin
      st_d.timer_clock_control = SFR_WDATA_I & TCS_TIMER_CLOCK_CONTROL_WMASK;
    end
    st_d.rdata = is_timer_clock_control(SFR_ADDR_I) ? st_q.timer_clock_control : 8'h00;
    // pins pass two flops before use
    st_d.gate_s1 = EXTERNAL_GATE_INPUT_A_I;
    st_d.gate_s2 = st_q.gate_s1;
    st_d.ev_s1 = {TIMER1_EVENT_I, TIMER0_EVENT_I};
    st_d.ev_s2 = st_q.ev_s1;
    st_d.ev_s3 = st_q.ev_s2;
    ev_fall = st_q.ev_s3 & ~st_q.ev_s2;
    for (int i = 0; i < 2; i++) begin
      // both timers share gate input a, each with its own polarity bit
      st_d.en[i] = gate_open(run[i], gen[i], st_q.gate_s2, pol[i]);
      if (cmode[i]) begin
        tick = ev_fall[i];
      end else if (sys[i]) begin
        tick = 1'b1;
      end else begin
        tick = presc_bus.tick_scaled;
      end
      st_d.ovf[i] = 1'b0;
      // run only gates ticks; the count itself is left untouched
      if (st_q.en[i] && tick) begin
        st_d.cnt[i] = st_q.cnt[i] + 1'b1;
        st_d.ovf[i] = &st_q.cnt[i];
      end
      // a load in the same cycle as a tick wins, so the written value sticks
      if (ld_lo[i]) begin
        st_d.cnt[i][TCS_LOW_W-1:0] = LOAD_DATA_I[TCS_LOW_W-1:0];
      end
      if (ld_hi[i]) begin
        st_d.cnt[i][CNT_W-1:TCS_LOW_W] = LOAD_DATA_I[CNT_W-TCS_LOW_W-1:0];
      end
    end
    // timer 2: 0 selects by ext-clock bit, /12 or synchronised external /8
    t2_src = TIMER2_EXT_CLOCK_SELECT_I ? presc_bus.tick_ext8 : presc_bus.tick_div12;
    st_d.t2_low = st_q.timer_clock_control[TCS_T2L_SYS_BIT] ? 1'b1 : t2_src;
    if (TIMER2_SPLIT_MODE_I) begin
      st_d.t2_high = st_q.timer_clock_control[TCS_T2H_SYS_BIT] ? 1'b1 : t2_src;
    end else begin
      st_d.t2_high = st_d.t2_low;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_q <= '0;
      st_q.timer_clock_control <= TCS_TIMER_CLOCK_CONTROL_RESET;
    end else if (CE_I) begin
      st_q <= st_d;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign SFR_RDATA_O = st_q.rdata;
  assign TIMER0_COUNT_O = st_q.cnt[0];
  assign TIMER1_COUNT_O = st_q.cnt[1];
  assign TIMER0_OVERFLOW_O = st_q.ovf[0];
  assign TIMER1_OVERFLOW_O = st_q.ovf[1];
  assign TIMER0_ENABLED_O = st_q.en[0];
  assign TIMER1_ENABLED_O = st_q.en[1];
  assign TIMER2_LOW_TICK_O = st_q.t2_low;
  assign TIMER2_HIGH_TICK_O = st_q.t2_high;
  assign TIMER_CLOCK_CONTROL_O = st_q.timer_clock_control;
endmodule
`default_nettype wire

// ==== dv/tcs_gate_properties.sv ====
// Purpose: port-level checks for timer clock select and gating
// Assumes: CE_I held high by the bench
// Notes: single clock domain
`timescale 1ns/1ps
`default_nettype none
module tcs_gate_properties #(parameter int CNT_W = 13) (
  // clock and reset
  input wire logic CLK_I, NRST_I,
  // register port
  input wire logic SFR_WE_I,
  input wire logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O, TIMER_CLOCK_CONTROL_O,
  // timer controls
  input wire logic TIMER0_RUN_I, TIMER0_GATE_ENABLE_I, TIMER0_COUNTER_MODE_I,
  input wire logic TIMER1_RUN_I, TIMER1_GATE_ENABLE_I, TIMER2_SPLIT_MODE_I,
  input wire logic TIMER0_LOAD_LOW_I, TIMER0_LOAD_HIGH_I,
  input wire logic [7:0] LOAD_DATA_I,
  // observed state
  input wire logic [CNT_W-1:0] TIMER0_COUNT_O,
  input wire logic TIMER0_ENABLED_O, TIMER1_ENABLED_O, TIMER2_LOW_TICK_O, TIMER2_HIGH_TICK_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  // ************
  // properties
  // ************
  a_t0_run_off: assert property (!TIMER0_RUN_I |=> !TIMER0_ENABLED_O)
    else $error("timer0 enabled without run");
  a_t0_gate_off: assert property (TIMER0_RUN_I && !TIMER0_GATE_ENABLE_I |=> TIMER0_ENABLED_O)
    else $error("timer0 not enabled");
  a_t1_run_off: assert property (!TIMER1_RUN_I |=> !TIMER1_ENABLED_O)
    else $error("timer1 enabled without run");
  a_t1_gate_off: assert property (TIMER1_RUN_I && !TIMER1_GATE_ENABLE_I |=> TIMER1_ENABLED_O)
    else $error("timer1 not enabled");
  a_reg_write: assert property (SFR_WE_I && SFR_ADDR_I == 8'h8E |=>
    TIMER_CLOCK_CONTROL_O == ($past(SFR_WDATA_I) & 8'h3F)) else $error("clock control write wrong");
  a_reg_read: assert property (1 |=> SFR_RDATA_O ==
    ($past(SFR_ADDR_I) == 8'h8E ? $past(TIMER_CLOCK_CONTROL_O) : 8'h00)) else $error("read data wrong");
  a_reserved_zero: assert property (TIMER_CLOCK_CONTROL_O[7:6] == 2'h0 && SFR_RDATA_O[7:6] == 2'h0)
    else $error("reserved bits set");
  a_t0_sys_count: assert property (TIMER0_ENABLED_O && TIMER_CLOCK_CONTROL_O[2] && !TIMER0_COUNTER_MODE_I
    && !TIMER0_LOAD_LOW_I && !TIMER0_LOAD_HIGH_I |=> TIMER0_COUNT_O == $past(TIMER0_COUNT_O) + 1'h1)
    else $error("timer0 missed system clock tick");
  a_t0_hold: assert property (!TIMER0_ENABLED_O && !TIMER0_LOAD_LOW_I && !TIMER0_LOAD_HIGH_I
    |=> $stable(TIMER0_COUNT_O)) else $error("disabled timer0 moved");
  a_t0_load_high: assert property (TIMER0_LOAD_HIGH_I |=> TIMER0_COUNT_O[CNT_W-1:5] == $past(LOAD_DATA_I))
    else $error("high load lost");
  a_t2_low_sys: assert property (TIMER_CLOCK_CONTROL_O[4] [*2] |-> TIMER2_LOW_TICK_O)
    else $error("timer2 low not on system clock");
  a_t2_high_follow: assert property (!TIMER2_SPLIT_MODE_I |=> TIMER2_HIGH_TICK_O == TIMER2_LOW_TICK_O)
    else $error("timer2 high select used outside split");
endmodule
bind tcs_timer_clk_gate tcs_gate_properties #(.CNT_W(CNT_W)) u_props (
  .CLK_I(CLK_I),
  .NRST_I(NRST_I),
  .SFR_WE_I(SFR_WE_I),
  .SFR_ADDR_I(SFR_ADDR_I),
  .SFR_WDATA_I(SFR_WDATA_I),
  .SFR_RDATA_O(SFR_RDATA_O),
  .TIMER_CLOCK_CONTROL_O(TIMER_CLOCK_CONTROL_O),
  .TIMER0_RUN_I(TIMER0_RUN_I),
  .TIMER0_GATE_ENABLE_I(TIMER0_GATE_ENABLE_I),
  .TIMER0_COUNTER_MODE_I(TIMER0_COUNTER_MODE_I),
  .TIMER1_RUN_I(TIMER1_RUN_I),
  .TIMER1_GATE_ENABLE_I(TIMER1_GATE_ENABLE_I),
  .TIMER2_SPLIT_MODE_I(TIMER2_SPLIT_MODE_I),
  .TIMER0_LOAD_LOW_I(TIMER0_LOAD_LOW_I),
  .TIMER0_LOAD_HIGH_I(TIMER0_LOAD_HIGH_I),
  .LOAD_DATA_I(LOAD_DATA_I),
  .TIMER0_COUNT_O(TIMER0_COUNT_O),
  .TIMER0_ENABLED_O(TIMER0_ENABLED_O),
  .TIMER1_ENABLED_O(TIMER1_ENABLED_O),
  .TIMER2_LOW_TICK_O(TIMER2_LOW_TICK_O),
  .TIMER2_HIGH_TICK_O(TIMER2_HIGH_TICK_O)
);
`default_nettype wire

// ==== dv/test_timer_clock_select_gating.sv ====
// Purpose: self-checking bench for timer clock select and gating
// Assumes: CE_I held high; external clock rises every 4 cycles
// Notes: random gating mixed with fixed corner cases
`timescale 1ns/1ps
`default_nettype none
module test_timer_clock_select_gating;
  import tcs_pkg::*;
  logic CLK_I = 0, NRST_I = 0, CE_I = 1, SFR_WE_I = 0, EXT_CLK_I = 0;
  logic TIMER0_RUN_I = 0, TIMER0_GATE_ENABLE_I = 0, TIMER0_COUNTER_MODE_I = 0, TIMER1_RUN_I = 0;
  logic TIMER1_GATE_ENABLE_I = 0, TIMER1_COUNTER_MODE_I = 0, GATE_A_POLARITY_I = 0, GATE_B_POLARITY_I = 0;
  logic TIMER2_EXT_CLOCK_SELECT_I = 0, TIMER2_SPLIT_MODE_I = 0, EXTERNAL_GATE_INPUT_A_I = 0;
  logic TIMER0_EVENT_I = 1, TIMER1_EVENT_I = 0, TIMER0_LOAD_LOW_I = 0, TIMER0_LOAD_HIGH_I = 0;
  logic TIMER1_LOAD_LOW_I = 0, TIMER1_LOAD_HIGH_I = 0;
  logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, LOAD_DATA_I = 8'h00, SFR_RDATA_O, TIMER_CLOCK_CONTROL_O;
  logic [12:0] TIMER0_COUNT_O, TIMER1_COUNT_O, v;
  logic TIMER0_OVERFLOW_O, TIMER1_OVERFLOW_O, TIMER0_ENABLED_O, TIMER1_ENABLED_O;
  logic TIMER2_LOW_TICK_O, TIMER2_HIGH_TICK_O;
  logic [7:0] r;
  int bad_count = 0, total_checks = 0, p;
  tcs_timer_clk_gate dut (.*);
  initial forever #5 CLK_I = ~CLK_I;
  // free external clock, period exactly 4 system clock cycles, edges on system clock falling edges
  initial forever #20 EXT_CLK_I = ~EXT_CLK_I;
  // ************
  // helpers
  // ************
  function automatic logic exp_en(input logic run, gate, pin, pol);
    return run && (!gate || pin == pol);
  endfunction
  function automatic int presc_cyc(input int s);
    int t[4] = '{12, 4, 48, 32};
    return t[s];
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      $display("Error at %0t got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    SFR_ADDR_I = a;
    SFR_WDATA_I = d;
    SFR_WE_I = 1;
    tick(1);
    SFR_WE_I = 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    SFR_ADDR_I = a;
    tick(1);
    chk(SFR_RDATA_O, e);
  endtask
  // third interval only: a select change lands at the next tick
  task automatic per(output int n);
    logic [12:0] c;
    repeat (3) begin
      c = TIMER0_COUNT_O;
      n = 0;
      while (TIMER0_COUNT_O === c) begin
        tick(1);
        n++;
        if (n > 200) begin
          bad_count++;
          give_verdict;
        end
      end
    end
  endtask
  task automatic t2(input logic [7:0] cfg, input logic sp, xs, input int el, eh);
    int l, h;
    wr(8'h8E, cfg);
    TIMER2_SPLIT_MODE_I = sp;
    TIMER2_EXT_CLOCK_SELECT_I = xs;
    tick(4);
    l = 0;
    h = 0;
    repeat (96) begin
      l += TIMER2_LOW_TICK_O;
      h += TIMER2_HIGH_TICK_O;
      tick(1);
    end
    chk(l, el);
    chk(h, eh);
  endtask
  // ************
  // sequence
  // ************
  initial begin
    void'($urandom(32'h869EFD98));
    tick(2);
    NRST_I = 1;
    rd(8'h8E, 8'h00);
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h3F);
    wr(8'h8D, 8'h00);
    rd(8'h8E, 8'h3F);
    rd(8'h8D, 8'h00);
    repeat (8) begin
      r = 8'($urandom);
      wr(8'h8E, r);
      rd(8'h8E, r & 8'h3F);
    end
    $display("register test done");
    for (int i = 0; i < 40; i++) begin
      {TIMER0_RUN_I, TIMER0_GATE_ENABLE_I, TIMER1_RUN_I, TIMER1_GATE_ENABLE_I, EXTERNAL_GATE_INPUT_A_I,
       GATE_A_POLARITY_I, GATE_B_POLARITY_I, TIMER1_COUNTER_MODE_I} = 8'($urandom);
      tick(5);
      chk(TIMER0_ENABLED_O, exp_en(TIMER0_RUN_I, TIMER0_GATE_ENABLE_I, EXTERNAL_GATE_INPUT_A_I, GATE_A_POLARITY_I));
      chk(TIMER1_ENABLED_O, exp_en(TIMER1_RUN_I, TIMER1_GATE_ENABLE_I, EXTERNAL_GATE_INPUT_A_I, GATE_B_POLARITY_I));
    end
    $display("gating test done");
    {TIMER0_RUN_I, TIMER0_GATE_ENABLE_I, TIMER1_RUN_I, TIMER1_GATE_ENABLE_I, TIMER1_COUNTER_MODE_I} = 5'h14;
    for (int s = 0; s < 4; s++) begin
      wr(8'h8E, 8'(s));
      per(p);
      chk(p, presc_cyc(s));
    end
    wr(8'h8E, 8'h04);
    per(p);
    chk(p, 1);
    // timer 0 stays on the system clock for the load and event tests
    wr(8'h8E, 8'h0C);
    v = TIMER1_COUNT_O;
    tick(10);
    chk(13'(TIMER1_COUNT_O - v), 13'h000A);
    $display("clock select test done");
    TIMER0_RUN_I = 0;
    tick(2);
    LOAD_DATA_I = 8'hFF;
    // start values go in before run is set; timer 1 load races its own tick
    {TIMER0_LOAD_LOW_I, TIMER0_LOAD_HIGH_I, TIMER1_LOAD_LOW_I, TIMER1_LOAD_HIGH_I} = 4'hF;
    tick(1);
    {TIMER0_LOAD_LOW_I, TIMER0_LOAD_HIGH_I, TIMER1_LOAD_LOW_I, TIMER1_LOAD_HIGH_I} = 4'h0;
    chk(TIMER0_COUNT_O, 13'h1FFF);
    chk(TIMER1_COUNT_O, 13'h1FFF);
    tick(1);
    chk({TIMER1_OVERFLOW_O, TIMER1_COUNT_O}, 14'h2000);
    TIMER0_RUN_I = 1;
    tick(2);
    chk(TIMER0_COUNT_O, 13'h0000);
    p = TIMER0_OVERFLOW_O;
    tick(1);
    p += TIMER0_OVERFLOW_O;
    tick(1);
    chk(p + TIMER0_OVERFLOW_O, 1);
    TIMER0_COUNTER_MODE_I = 1;
    tick(4);
    v = TIMER0_COUNT_O;
    tick(6);
    chk(TIMER0_COUNT_O, v);
    TIMER0_EVENT_I = 0;
    tick(6);
    chk(TIMER0_COUNT_O, 13'(v + 1));
    TIMER0_COUNTER_MODE_I = 0;
    $display("load and event test done");
    t2(8'h10, 0, 0, 96, 96);
    t2(8'h00, 0, 0, 8, 8);
    t2(8'h00, 0, 1, 3, 3);
    t2(8'h20, 1, 0, 8, 96);
    t2(8'h20, 0, 0, 8, 8);
    t2(8'h10, 1, 1, 96, 3);
    $display("timer2 test done");
    give_verdict;
  end
endmodule
`default_nettype wire
